// *** verilog/fcp_map.svh ***
// register offsets, field positions, reset values and timing for the command parameter block
// assumes a 20 MHz pclk and a 32-bit apb with byte addressing
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH
`define FCP_OFS_CMD 8'h00
`define FCP_OFS_PARAM 8'h04
`define FCP_OFS_CFG 8'h08
`define FCP_OFS_STAT 8'h0c
`define FCP_OFS_RESULT 8'h10
`define FCP_CFG_RESET 32'h0000_0000
`define FCP_CFG_STEP_LSB 0
`define FCP_CFG_POLL_DIS_BIT 4
`define FCP_CFG_WTA_BIT 5
`define FCP_CFG_OW_BIT 6
`define FCP_CFG_PERP_LSB 8
`define FCP_CFG_PRECOMP_START_TRACK_LSB 16
`define FCP_CLK_KHZ 20000
`define FCP_STEP_UNIT_US 500
`define FCP_POLL_PERIOD_US 1000
`define FCP_BASE_SECTOR_BYTES 16'h0080
`define FCP_MAX_SIZE_CODE 3'h7
`define FCP_FIRST_SECTOR 8'h01
`define FCP_RESULT_BYTES 3'h5
`endif

// *** verilog/fcp_pkg.sv ***
// types shared by the command parameter block
// assumes fcp_map.svh supplies all numeric constants except the opcode and state encodings defined here
package fcp_pkg;
  typedef enum logic [3:0] {
    FCP_OP_READ = 4'h0,
    FCP_OP_READ_DEL = 4'h1,
    FCP_OP_WRITE = 4'h2,
    FCP_OP_VERIFY = 4'h3,
    FCP_OP_FORMAT = 4'h4,
    FCP_OP_SEEK_ABS = 4'h5,
    FCP_OP_SEEK_REL = 4'h6,
    FCP_OP_SENSE = 4'h7
  } fcp_op_t;
  typedef struct packed {
    logic multi_track_flag;
    logic deleted_skip_flag;
    logic no_dma_flag;
    logic verify_count_enable;
    fcp_op_t op;
  } fcp_cmd_t;
  typedef struct packed {
    logic [7:0] cylinder;
    logic head;
    logic [7:0] sector;
    logic [2:0] size_code;
    logic [7:0] end_sector;
    logic [7:0] data_length;
    logic [7:0] sectors_per_track;
    logic [7:0] new_cylinder_target;
    logic [7:0] relative_cylinder_offset;
  } fcp_params_t;
  typedef enum logic [6:0] {
    FCP_IDLE = 7'b000_0001,
    FCP_PARAM = 7'b000_0010,
    FCP_STEP = 7'b000_0100,
    FCP_SECT = 7'b000_1000,
    FCP_XFER = 7'b001_0000,
    FCP_RESULT = 7'b010_0000,
    FCP_DONE = 7'b100_0000
  } fcp_state_t;
endpackage

// *** verilog/fcp_top.sv ***
// floppy command parameter interpreter: apb slave, parameter latch, sector/seek sequencer
// assumes drive side inputs are synchronous to pclk; one apb register per aligned word
//
// The register offsets and the APB register port are this design's own decisions.
`include "fcp_map.svh"

// Functional notes
// - multi-track continues head 0 into head 1
// - sector size is 128 shifted by code
// - code zero takes byte count from length
// - no-dma interrupts per byte, else dma requests
// - perpendicular bits change only with overwrite set
// - sense reports present cylinder as result
// - polling disable bit stops drive polling
// - precompensation from programmed start track onward
// - multi-sector transfer starts at given sector
// - relative seek moves offset from present cylinder
// - absolute seek targets new cylinder value
// - sectors per track bounds format and counted verify
// - skip flag passes deleted sectors on read
// - skip with read-deleted takes deleted sectors only
// - skip clear reads every sector, flagging a mismatched mark with 0x40 in the third status byte
// - step pulses spaced half millisecond times code+1
// - status bytes held and read in result phase
// - write timing adjust moves write enable earlier
module fcp_top #(
  parameter int unsigned STEP_UNIT_CYCLES = `FCP_STEP_UNIT_US * `FCP_CLK_KHZ / 1000,
  parameter int unsigned POLL_CYCLES = `FCP_POLL_PERIOD_US * `FCP_CLK_KHZ / 1000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic disk_sector_found,
  input wire logic [7:0] disk_sector_id,
  input wire logic disk_sector_deleted,
  input wire logic disk_byte_strobe,
  input wire logic dma_ack,
  output logic dma_req,
  output logic data_irq,
  output logic step_pulse,
  output logic step_dir,
  output logic head_select,
  output logic write_enable,
  output logic precomp_enable,
  output logic poll_pulse,
  output logic [3:0] perp_mode_bits
);
  localparam logic [15:0] STEP_UNIT = 16'(STEP_UNIT_CYCLES);
  localparam logic [15:0] POLL_LEN = 16'(POLL_CYCLES);

  // bytes each opcode expects after the command word
  function automatic logic [2:0] param_count(input fcp_pkg::fcp_op_t op);
    unique case (op)
      fcp_pkg::FCP_OP_READ, fcp_pkg::FCP_OP_READ_DEL, fcp_pkg::FCP_OP_WRITE: param_count = 3'h6;
      fcp_pkg::FCP_OP_VERIFY, fcp_pkg::FCP_OP_FORMAT: param_count = 3'h7;
      fcp_pkg::FCP_OP_SEEK_ABS, fcp_pkg::FCP_OP_SEEK_REL: param_count = 3'h1;
      default: param_count = 3'h0;
    endcase
  endfunction

  fcp_pkg::fcp_state_t state_q, state_d;
  fcp_pkg::fcp_cmd_t cmd_q;
  fcp_pkg::fcp_params_t prm_q;
  logic [31:0] cfg_q;
  logic [3:0] perp_q;
  logic [2:0] pidx_q;
  logic [7:0] pcyl_q, target_q, sector_q;
  logic head_q;
  logic [15:0] bytes_q, tick_q, poll_q;
  logic [3:0] unit_q;
  logic [7:0] stat_a_q, stat_b_q, stat_c_q, stat_d_q;
  logic [2:0] ridx_q, rlen_q;
  logic dma_req_q, irq_q, step_q, dir_q, we_q, poll_pulse_q;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire hit_cmd = paddr == `FCP_OFS_CMD;
  wire hit_param = paddr == `FCP_OFS_PARAM;
  wire hit_cfg = paddr == `FCP_OFS_CFG;
  wire hit_stat = paddr == `FCP_OFS_STAT;
  wire hit_res = paddr == `FCP_OFS_RESULT;
  wire mapped = hit_cmd | hit_param | hit_cfg | hit_stat | hit_res;
  wire idle = state_q == fcp_pkg::FCP_IDLE;
  wire cmd_go = wr_acc & hit_cmd & idle;
  wire param_wr = wr_acc & hit_param & (state_q == fcp_pkg::FCP_PARAM);
  wire res_pop = rd_acc & hit_res & (state_q == fcp_pkg::FCP_RESULT);
  wire fcp_pkg::fcp_cmd_t new_cmd = fcp_pkg::fcp_cmd_t'(pwdata[7:0]);
  wire [2:0] need = param_count(cmd_q.op);
  wire last_param = param_wr & (pidx_q + 3'h1 == need);
  wire is_seek = (cmd_q.op == fcp_pkg::FCP_OP_SEEK_ABS) | (cmd_q.op == fcp_pkg::FCP_OP_SEEK_REL);
  wire is_sense = cmd_q.op == fcp_pkg::FCP_OP_SENSE;
  wire is_write = (cmd_q.op == fcp_pkg::FCP_OP_WRITE) | (cmd_q.op == fcp_pkg::FCP_OP_FORMAT);
  wire [3:0] step_code = cfg_q[`FCP_CFG_STEP_LSB +: 4];
  wire poll_dis = cfg_q[`FCP_CFG_POLL_DIS_BIT];
  wire wta = cfg_q[`FCP_CFG_WTA_BIT];
  wire [7:0] precomp_start_track = cfg_q[`FCP_CFG_PRECOMP_START_TRACK_LSB +: 8];

  // seek target: absolute value, or signed offset from the present cylinder
  // taken from the byte in flight, since the parameter latch only settles at that same edge
  wire [7:0] rel_target = 8'(pcyl_q + pwdata[7:0]);
  wire [7:0] seek_target = (cmd_q.op == fcp_pkg::FCP_OP_SEEK_ABS) ?
                           pwdata[7:0] : rel_target;

  // sector length; code zero uses the host length byte instead
  wire [2:0] size_c = prm_q.size_code;
  wire [15:0] sect_bytes = (size_c == 3'h0) ? {8'h00, prm_q.data_length} :
                           (`FCP_BASE_SECTOR_BYTES << size_c);

  // last sector on a side: counted operations stop at sectors per track
  wire use_sc = (cmd_q.op == fcp_pkg::FCP_OP_FORMAT) |
                ((cmd_q.op == fcp_pkg::FCP_OP_VERIFY) & cmd_q.verify_count_enable);
  wire [7:0] last_sector = use_sc ? prm_q.sectors_per_track : prm_q.end_sector;
  wire side_end = sector_q == last_sector;
  wire mt_wrap = side_end & cmd_q.multi_track_flag & ~head_q;
  wire op_end = side_end & ~mt_wrap;

  // which sectors are taken; the rest pass by without data
  wire id_match = disk_sector_found & (disk_sector_id == sector_q);
  wire rd_skip = (cmd_q.op == fcp_pkg::FCP_OP_READ) & disk_sector_deleted;
  wire rdd_skip = (cmd_q.op == fcp_pkg::FCP_OP_READ_DEL) & ~disk_sector_deleted;
  wire skip_sect = cmd_q.deleted_skip_flag & (rd_skip | rdd_skip);
  wire mark_mismatch = ~cmd_q.deleted_skip_flag & (rd_skip | rdd_skip);
  wire take_sect = (state_q == fcp_pkg::FCP_SECT) & id_match & ~skip_sect;
  wire pass_sect = (state_q == fcp_pkg::FCP_SECT) & id_match & skip_sect;
  wire xfer_byte = (state_q == fcp_pkg::FCP_XFER) & disk_byte_strobe;
  wire sect_done = xfer_byte & (bytes_q == 16'h0001);
  wire advance = pass_sect | sect_done;

  wire step_tick = (state_q == fcp_pkg::FCP_STEP) & (tick_q == 16'h0000);
  wire step_last_unit = unit_q == step_code;
  wire at_target = pcyl_q == target_q;
  wire [7:0] res_byte = (ridx_q == 3'h0) ? stat_a_q :
                        is_sense ? pcyl_q :
                        (ridx_q == 3'h1) ? stat_b_q :
                        (ridx_q == 3'h2) ? stat_c_q :
                        (ridx_q == 3'h3) ? stat_d_q : pcyl_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fcp_pkg::FCP_IDLE: if (cmd_go) begin
        state_d = (param_count(new_cmd.op) == 3'h0) ? fcp_pkg::FCP_DONE : fcp_pkg::FCP_PARAM;
      end
      fcp_pkg::FCP_PARAM: if (last_param) begin
        state_d = is_seek ? fcp_pkg::FCP_STEP : fcp_pkg::FCP_SECT;
      end
      fcp_pkg::FCP_STEP: if (at_target) begin
        state_d = fcp_pkg::FCP_DONE;
      end
      fcp_pkg::FCP_SECT: if (take_sect) begin
        state_d = fcp_pkg::FCP_XFER;
      end else if (pass_sect & op_end) begin
        state_d = fcp_pkg::FCP_DONE;
      end
      fcp_pkg::FCP_XFER: if (sect_done) begin
        state_d = op_end ? fcp_pkg::FCP_DONE : fcp_pkg::FCP_SECT;
      end
      fcp_pkg::FCP_DONE: state_d = fcp_pkg::FCP_RESULT;
      fcp_pkg::FCP_RESULT: if (res_pop & (ridx_q + 3'h1 == rlen_q)) begin
        state_d = fcp_pkg::FCP_IDLE;
      end
      default: state_d = fcp_pkg::FCP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= fcp_pkg::FCP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // command word and parameter bytes, one field per byte in arrival order; a seek byte loads both seek fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= '0;
      prm_q <= '0;
      pidx_q <= 3'h0;
    end else if (cmd_go) begin
      cmd_q <= new_cmd;
      pidx_q <= 3'h0;
    end else if (param_wr) begin
      pidx_q <= pidx_q + 3'h1;
      if (is_seek) begin
        prm_q.new_cylinder_target <= pwdata[7:0];
        prm_q.relative_cylinder_offset <= pwdata[7:0];
      end else begin
        unique case (pidx_q)
          3'h0: prm_q.cylinder <= pwdata[7:0];
          3'h1: prm_q.head <= pwdata[0];
          3'h2: prm_q.sector <= pwdata[7:0];
          3'h3: prm_q.size_code <= pwdata[2:0];
          3'h4: prm_q.end_sector <= pwdata[7:0];
          3'h5: prm_q.data_length <= pwdata[7:0];
          default: prm_q.sectors_per_track <= pwdata[7:0];
        endcase
      end
    end
  end

  // configuration; perpendicular bits only move when the overwrite bit is written high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `FCP_CFG_RESET;
      perp_q <= 4'h0;
    end else if (wr_acc & hit_cfg) begin
      cfg_q <= pwdata;
      if (pwdata[`FCP_CFG_OW_BIT]) begin
        perp_q <= pwdata[`FCP_CFG_PERP_LSB +: 4];
      end
    end
  end

  // position sequencer: start sector, head, byte count, seek target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sector_q <= 8'h00;
      head_q <= 1'b0;
      bytes_q <= 16'h0000;
      target_q <= 8'h00;
    end else if (last_param) begin
      sector_q <= (cmd_q.op == fcp_pkg::FCP_OP_FORMAT) ? `FCP_FIRST_SECTOR : prm_q.sector;
      head_q <= prm_q.head;
      target_q <= seek_target;
    end else begin
      if (take_sect) begin
        bytes_q <= sect_bytes;
      end else if (xfer_byte) begin
        bytes_q <= bytes_q - 16'h0001;
      end
      if (advance & mt_wrap) begin
        head_q <= 1'b1;
        sector_q <= `FCP_FIRST_SECTOR;
      end else if (advance & ~side_end) begin
        sector_q <= sector_q + 8'h01;
      end
    end
  end

  // step timing: a tick every half-millisecond unit, a step after code+1 units
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 16'h0000;
      unit_q <= 4'h0;
      pcyl_q <= 8'h00;
      step_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      step_q <= 1'b0;
      if (state_q != fcp_pkg::FCP_STEP) begin
        tick_q <= STEP_UNIT - 16'h0001;
        unit_q <= 4'h0;
      end else if (step_tick) begin
        tick_q <= STEP_UNIT - 16'h0001;
        unit_q <= step_last_unit ? 4'h0 : unit_q + 4'h1;
        if (step_last_unit & ~at_target) begin
          step_q <= 1'b1;
          dir_q <= target_q > pcyl_q;
          pcyl_q <= (target_q > pcyl_q) ? pcyl_q + 8'h01 : pcyl_q - 8'h01;
        end
      end else begin
        tick_q <= tick_q - 16'h0001;
      end
    end
  end

  // data requests: dma holds until acknowledged, new byte wins over the ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req_q <= 1'b0;
      irq_q <= 1'b0;
      we_q <= 1'b0;
    end else begin
      irq_q <= xfer_byte & cmd_q.no_dma_flag;
      if (xfer_byte & ~cmd_q.no_dma_flag) begin
        dma_req_q <= 1'b1;
      end else if (dma_ack) begin
        dma_req_q <= 1'b0;
      end
      // adjusted timing raises the gate at the sector match for pre-erase
      if (is_write & take_sect & wta) begin
        we_q <= 1'b1;
      end else if (is_write & xfer_byte) begin
        we_q <= ~sect_done;
      end else if (state_q != fcp_pkg::FCP_XFER) begin
        we_q <= 1'b0;
      end
    end
  end

  // status bytes captured as the command ends, the third byte at a mismatched sector match, and read out one per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_a_q <= 8'h00;
      stat_b_q <= 8'h00;
      stat_c_q <= 8'h00;
      stat_d_q <= 8'h00;
      ridx_q <= 3'h0;
      rlen_q <= 3'h0;
    end else if (cmd_go) begin
      stat_c_q <= 8'h00;
    end else if (take_sect & mark_mismatch) begin
      stat_c_q <= 8'h40;
    end else if (state_q == fcp_pkg::FCP_DONE) begin
      stat_a_q <= {2'b00, is_seek | is_sense, 4'h0, head_q};
      stat_b_q <= {side_end, 7'h00};
      stat_d_q <= {3'b000, pcyl_q == 8'h00, 3'b000, head_q};
      ridx_q <= 3'h0;
      rlen_q <= is_sense ? 3'h2 : `FCP_RESULT_BYTES;
    end else if (res_pop) begin
      ridx_q <= ridx_q + 3'h1;
    end
  end

  // drive polling runs only when idle and not disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_q <= 16'h0000;
      poll_pulse_q <= 1'b0;
    end else begin
      poll_pulse_q <= 1'b0;
      if (poll_dis | ~idle) begin
        poll_q <= POLL_LEN - 16'h0001;
      end else if (poll_q == 16'h0000) begin
        poll_q <= POLL_LEN - 16'h0001;
        poll_pulse_q <= 1'b1;
      end else begin
        poll_q <= poll_q - 16'h0001;
      end
    end
  end

  wire [31:0] stat_word = {16'h0000, pcyl_q, 1'b0, state_q};
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = ~rd_acc ? 32'h0000_0000 :
                  hit_cmd ? {24'h00_0000, cmd_q} :
                  hit_cfg ? cfg_q :
                  hit_stat ? stat_word :
                  (hit_res & (state_q == fcp_pkg::FCP_RESULT)) ? {24'h00_0000, res_byte} :
                  32'h0000_0000;
  assign dma_req = dma_req_q;
  assign data_irq = irq_q;
  assign step_pulse = step_q;
  assign step_dir = dir_q;
  assign head_select = head_q;
  assign write_enable = we_q;
  assign precomp_enable = pcyl_q >= precomp_start_track;
  assign poll_pulse = poll_pulse_q;
  assign perp_mode_bits = perp_q;
endmodule

// *** test/fcp_sva.sv ***
// checker for fcp_top, sees only its ports
// assumes the bind hands on the shortened step and poll counts
`include "fcp_map.svh"
module fcp_sva #(
  parameter int unsigned STEP_UNIT_CYCLES = 4,
  parameter int unsigned POLL_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic disk_byte_strobe,
  input wire logic dma_ack,
  input wire logic dma_req,
  input wire logic data_irq,
  input wire logic step_pulse,
  input wire logic poll_pulse,
  input wire logic [3:0] perp_mode_bits
);
  logic [15:0] sgap_q, pgap_q;
  logic dis_q;
  wire logic acc = psel && penable;
  wire logic map_ok = paddr[1:0] == 2'h0 && paddr <= `FCP_OFS_RESULT;
  wire logic cfg_wr = acc && pwrite && paddr == `FCP_OFS_CFG;
  wire logic ow_wr = cfg_wr && pwdata[`FCP_CFG_OW_BIT];
  wire logic [3:0] perp_in = pwdata[11:8];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // gap counters saturate so a long idle spell cannot wrap into a false short gap
  // they start saturated: a first pulse right after reset has no earlier pulse to be near
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sgap_q <= '1;
      pgap_q <= '1;
      dis_q <= 1'b0;
    end else begin
      sgap_q <= step_pulse ? '0 : sgap_q + 16'(sgap_q != 16'hFFFF);
      pgap_q <= poll_pulse ? '0 : pgap_q + 16'(pgap_q != 16'hFFFF);
      if (cfg_wr) dis_q <= pwdata[`FCP_CFG_POLL_DIS_BIT];
    end
  end
  AST_PREADY: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_SLVERR: assert property (acc |-> pslverr == !map_ok)
    else $error("pslverr does not match address map");
  AST_PRDATA: assert property (!(acc && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside read access");
  AST_IRQ: assert property (data_irq |-> $past(disk_byte_strobe))
    else $error("data_irq without a byte");
  AST_DMA_RISE: assert property ($rose(dma_req) |-> $past(disk_byte_strobe))
    else $error("dma_req rose without a byte");
  AST_DMA_FALL: assert property ($fell(dma_req) |-> $past(dma_ack))
    else $error("dma_req dropped without dma_ack");
  AST_STEP: assert property (step_pulse |-> sgap_q >= STEP_UNIT_CYCLES - 1)
    else $error("step pulses too close");
  AST_PERP: assert property (!$stable(perp_mode_bits) |->
    $past(ow_wr) && perp_mode_bits == $past(perp_in))
    else $error("perp bits changed without overwrite");
  AST_POLL: assert property (poll_pulse |-> !$past(dis_q) && pgap_q >= POLL_CYCLES - 2)
    else $error("poll pulse while disabled or too soon");
  COV_STEP: cover property (step_pulse);
  COV_IRQ: cover property (data_irq);
  COV_DMA: cover property ($rose(dma_req));
endmodule
bind fcp_top fcp_sva #(.STEP_UNIT_CYCLES(STEP_UNIT_CYCLES), .POLL_CYCLES(POLL_CYCLES)) sva_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .disk_byte_strobe, .dma_ack, .dma_req, .data_irq, .step_pulse, .poll_pulse,
  .perp_mode_bits);

// *** test/fcp_disk_model.sv ***
// drive model: one sector header on go, then its data bytes every fourth cycle
// assumes go is a one-cycle pulse from the bench
module fcp_disk_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [7:0] sid,
  input wire logic del,
  input wire logic [15:0] nb,
  output logic disk_sector_found,
  output logic [7:0] disk_sector_id,
  output logic disk_sector_deleted,
  output logic disk_byte_strobe,
  output logic busy
);
  logic [17:0] cnt_q;
  // header fields show the inverse outside the header so a stale value never matches
  assign disk_sector_id = disk_sector_found ? sid : ~sid;
  assign disk_sector_deleted = disk_sector_found ? del : ~del;
  assign busy = disk_sector_found || cnt_q != '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disk_sector_found <= 1'b0;
      disk_byte_strobe <= 1'b0;
      cnt_q <= '0;
    end else begin
      disk_sector_found <= go;
      disk_byte_strobe <= cnt_q[1:0] == 2'h1;
      cnt_q <= go ? {nb, 2'h0} : cnt_q - 18'(cnt_q != '0);
    end
  end
endmodule

// *** test/floppy_command_parameters_tb.sv ***
// bench for fcp_top: apb host tasks, drive model, one task per scenario
// assumes fcp_sva is bound in and the step unit and poll period are shortened
`include "fcp_map.svh"
module floppy_command_parameters_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dma_ack = 0;
  logic go = 0, del = 0, dreq_q = 0, err, busy;
  logic [7:0] paddr = '0, sid = '0, disk_sector_id;
  logic [31:0] pwdata = '0, prdata, rv;
  logic [15:0] nb = '0;
  logic pready, pslverr, disk_sector_found, disk_sector_deleted, disk_byte_strobe;
  logic dma_req, data_irq, step_pulse, step_dir, head_select, write_enable;
  logic precomp_enable, poll_pulse;
  logic [3:0] perp_mode_bits;
  logic [7:0] res [5];
  int n_mismatch = 0, check_count = 0, n_step = 0, n_irq = 0, n_dma = 0, n_poll = 0, s0, s1;
  int n_we = 0;
  fcp_top #(.STEP_UNIT_CYCLES(4), .POLL_CYCLES(8)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .disk_sector_found, .disk_sector_id, .disk_sector_deleted, .disk_byte_strobe, .dma_ack,
    .dma_req, .data_irq, .step_pulse, .step_dir, .head_select, .write_enable,
    .precomp_enable, .poll_pulse, .perp_mode_bits);
  fcp_disk_model disk_u (.pclk, .presetn, .go, .sid, .del, .nb, .disk_sector_found,
    .disk_sector_id, .disk_sector_deleted, .disk_byte_strobe, .busy);
  initial begin
    forever #25 pclk = ~pclk;
  end
  always_ff @(posedge pclk) begin
    dma_ack <= dma_req;
    dreq_q <= dma_req;
    n_step <= n_step + int'(step_pulse);
    n_irq <= n_irq + int'(data_irq);
    n_dma <= n_dma + int'(dma_req && !dreq_q);
    n_poll <= n_poll + int'(poll_pulse);
    n_we <= n_we + int'(write_enable);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    end_sim();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1) hang();
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c, input int n, input logic [7:0] p [7]);
    apb(1'b1, `FCP_OFS_CMD, {24'h00_0000, c});
    for (int i = 0; i < n; i++) apb(1'b1, `FCP_OFS_PARAM, {24'h00_0000, p[i]});
  endtask
  // waits for idle or result phase; done is only a one-cycle passage
  task automatic wait_end;
    int k;
    for (k = 0; k < 1000; k++) begin
      apb(1'b0, `FCP_OFS_STAT, '0);
      if ((rv[6:0] & 7'h21) != 7'h00) break;
    end
    if (k == 1000) hang();
  endtask
  task automatic disk(input logic [7:0] i, input logic dl, input logic [15:0] n);
    int k;
    @(posedge pclk);
    sid <= i;
    del <= dl;
    nb <= n;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (k = 0; k < 2000 && (busy !== 1'b0 || k < 2); k++) @(posedge pclk);
    if (k == 2000) hang();
  endtask
  task automatic results(input int n);
    for (int i = 0; i < n; i++) begin
      apb(1'b0, `FCP_OFS_RESULT, '0);
      res[i] = rv[7:0];
    end
  endtask
  task automatic t_regs;
    apb(1'b0, `FCP_OFS_CFG, '0);
    chk(rv, `FCP_CFG_RESET);
    apb(1'b0, `FCP_OFS_STAT, '0);
    chk(rv[6:0], 7'h01);
    apb(1'b0, 8'h14, '0);
    chk(err, 1'b1);
    apb(1'b1, `FCP_OFS_CFG, 32'h0003_0A41);
    apb(1'b1, `FCP_OFS_CFG, 32'h0003_0501);
    chk(perp_mode_bits, 4'hA);
    chk(precomp_enable, 1'b0);
    s0 = n_poll;
    repeat (40) @(posedge pclk);
    chk(n_poll - s0 >= 4, 1'b1);
    apb(1'b1, `FCP_OFS_CFG, 32'h0003_0511);
    repeat (2) @(posedge pclk);
    s0 = n_poll;
    repeat (40) @(posedge pclk);
    chk(n_poll - s0, 0);
    $display("test regs done");
  endtask
  task automatic t_seek;
    s0 = n_step;
    cmd(8'h05, 1, '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    wait_end();
    chk(n_step - s0, 5);
    chk(step_dir, 1'b1);
    chk(precomp_enable, 1'b1);
    results(5);
    chk(res[4], 8'h05);
    s0 = n_step;
    cmd(8'h06, 1, '{8'hFE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    wait_end();
    chk(n_step - s0, 2);
    chk(step_dir, 1'b0);
    chk(precomp_enable, 1'b1);
    results(5);
    chk(res[4], 8'h03);
    cmd(8'h07, 0, '{default: 8'h00});
    wait_end();
    results(2);
    chk(res[0][5], 1'b1);
    chk(res[1], 8'h03);
    $display("test seek done");
  endtask
  task automatic t_nodma;
    s0 = n_irq;
    s1 = n_dma;
    cmd(8'h20, 6, '{8'h03, 8'h00, 8'h02, 8'h00, 8'h02, 8'h03, 8'h00});
    disk(8'h02, 1'b0, 16'h0003);
    wait_end();
    chk(n_irq - s0, 3);
    chk(n_dma - s1, 0);
    results(5);
    chk(res[0][0], 1'b0);
    chk(res[4], 8'h03);
    $display("test no-dma read done");
  endtask
  task automatic t_dma;
    s0 = n_dma;
    s1 = n_irq;
    cmd(8'h40, 6, '{8'h03, 8'h00, 8'h04, 8'h01, 8'h05, 8'hFF, 8'h00});
    disk(8'h03, 1'b0, 16'h0010);
    chk(n_dma - s0, 0);
    disk(8'h04, 1'b1, 16'h0100);
    chk(n_dma - s0, 0);
    disk(8'h05, 1'b0, 16'h0100);
    wait_end();
    chk(n_dma - s0, 256);
    chk(n_irq - s1, 0);
    results(5);
    chk(res[4], 8'h03);
    $display("test dma skip read done");
  endtask
  // adjusted write timing holds the gate from the header match, 8 cycles a 2-byte sector
  task automatic t_mtwrite;
    s0 = n_we;
    apb(1'b1, `FCP_OFS_CFG, 32'h0003_0531);
    cmd(8'h82, 6, '{8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00});
    disk(8'h01, 1'b0, 16'h0002);
    disk(8'h01, 1'b0, 16'h0002);
    wait_end();
    chk(head_select, 1'b1);
    chk(n_we - s0, 16);
    results(5);
    chk(res[0][0], 1'b1);
    chk(res[1][7], 1'b1);
    $display("test multi-track write done");
  endtask
  task automatic t_rdd;
    s0 = n_irq;
    cmd(8'h21, 6, '{8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00});
    disk(8'h01, 1'b0, 16'h0002);
    wait_end();
    chk(n_irq - s0, 2);
    results(5);
    chk(res[2], 8'h40);
    s0 = n_irq;
    cmd(8'h61, 6, '{8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00});
    disk(8'h01, 1'b0, 16'h0002);
    wait_end();
    chk(n_irq - s0, 0);
    results(5);
    chk(res[2], 8'h00);
    $display("test read deleted done");
  endtask
  // end sector 09 must be ignored: the format ends at sectors per track
  task automatic t_format;
    s0 = n_dma;
    cmd(8'h04, 7, '{8'h03, 8'h00, 8'h09, 8'h00, 8'h09, 8'h02, 8'h02});
    disk(8'h01, 1'b0, 16'h0002);
    disk(8'h02, 1'b0, 16'h0002);
    wait_end();
    chk(n_dma - s0, 4);
    results(5);
    chk(res[1][7], 1'b1);
    $display("test format done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_seek();
    t_nodma();
    t_dma();
    t_mtwrite();
    t_rdd();
    t_format();
    end_sim();
  end
endmodule
